// file: cnes_pkg.sv
package cnes_pkg;

	// Clock and time base.
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES_DFLT = MS_TIME_NS / CLK_PERIOD_NS;
	localparam int INIT_CYCLES_DFLT = 16;

	// Network management states, one-hot.
	typedef enum logic [3:0] {
		ST_INIT = 4'b0001,
		ST_PREOP = 4'b0010,
		ST_OPER = 4'b0100,
		ST_STOP = 4'b1000
	} cnes_state_t;

	// State codes carried in boot-up, guard and heartbeat frames.
	localparam logic [6:0] CODE_BOOT = 7'h00;
	localparam logic [6:0] CODE_STOP = 7'h04;
	localparam logic [6:0] CODE_OPER = 7'h05;
	localparam logic [6:0] CODE_PREOP = 7'h7F;

	// Frame identifiers and command specifiers.
	localparam logic [10:0] ID_NMT = 11'h000;
	localparam logic [10:0] ID_EMCY_BASE = 11'h080;
	localparam logic [10:0] ID_RPDO_BASE = 11'h200;
	localparam logic [10:0] ID_SDO_RX_BASE = 11'h600;
	localparam logic [10:0] ID_GUARD_BASE = 11'h700;
	localparam logic [3:0] NMT_DLC = 4'h2;
	localparam logic [3:0] EMCY_DLC = 4'h8;
	localparam logic [3:0] STATE_DLC = 4'h1;
	localparam logic [7:0] NODE_BCAST = 8'h00;
	localparam logic [7:0] CS_START = 8'h01;
	localparam logic [7:0] CS_STOP = 8'h02;
	localparam logic [7:0] CS_PREOP = 8'h80;
	localparam logic [7:0] CS_RESET_NODE = 8'h81;
	localparam logic [7:0] CS_RESET_COMM = 8'h82;

	// Emergency sources, lowest index is sent first.
	localparam int NSRC = 9;
	localparam int SRC_CLR = 0;
	localparam int SRC_BATT = 1;
	localparam int SRC_MAP = 2;
	localparam int SRC_HBC = 3;
	localparam int SRC_SDOB = 4;
	localparam int SRC_GUARD = 5;
	localparam int SRC_PDO_SHORT = 6;
	localparam int SRC_PDO_LONG = 7;
	localparam int SRC_CANERR = 8;
	localparam logic [15:0] EC_RESET = 16'h0000;
	localparam logic [15:0] EC_BATT = 16'h3200;
	localparam logic [15:0] EC_MAP = 16'h6300;
	localparam logic [15:0] EC_HBC = 16'h8100;
	localparam logic [15:0] EC_SDOB = 16'h8100;
	localparam logic [15:0] EC_GUARD = 16'h8130;
	localparam logic [15:0] EC_PDO_SHORT = 16'h8210;
	localparam logic [15:0] EC_PDO_LONG = 16'h8220;
	localparam logic [15:0] EC_CANERR = 16'h8110;
	localparam logic [7:0] INFO_BATT = 8'hA0;
	localparam logic [7:0] INFO_SDOB = 8'hF1;
	localparam logic [7:0] RPDO_NUMBER = 8'h01;

	// Register map, byte addresses, and power-on values.
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_NODE_ID = 8'h04;
	localparam logic [7:0] ADDR_GUARD_TIME = 8'h08;
	localparam logic [7:0] ADDR_LIFE = 8'h0C;
	localparam logic [7:0] ADDR_HB_TIME = 8'h10;
	localparam logic [7:0] ADDR_ERR_REG = 8'h14;
	localparam logic [7:0] ADDR_RPDO_LEN = 8'h18;
	localparam int STAT_GUARD_BIT = 8;
	localparam int STAT_EMCY_BIT = 9;
	localparam logic [15:0] GUARD_TIME_DFLT = 16'h0000;
	localparam logic [7:0] LIFE_DFLT = 8'h00;
	localparam logic [15:0] HB_TIME_DFLT = 16'h0000;
	localparam logic [7:0] ERR_REG_DFLT = 8'h00;
	localparam logic [3:0] RPDO_LEN_DFLT = 4'h8;
	localparam logic [6:0] NODE_ID_DFLT = 7'h01;

endpackage : cnes_pkg

// file: cnes_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cnes_ms_timer
	import cnes_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DFLT,
	parameter int W = 24
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic restart,
	input wire logic [W-1:0] period_ms,
	output logic expired
);

	localparam int PW = $clog2(MS_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

	logic [PW-1:0] pre_reg, pre_next;
	logic [W-1:0] ms_reg, ms_next;
	logic exp_reg, exp_next;

	// A zero period keeps the timer parked, so it never fires.
	always_comb
	begin
		pre_next = pre_reg + PW'(1);
		ms_next = ms_reg;
		exp_next = 1'b0;
		if (restart || period_ms == '0)
		begin
			pre_next = '0;
			ms_next = '0;
		end
		else if (pre_reg == PRE_LAST)
		begin
			pre_next = '0;
			ms_next = ms_reg + W'(1);
			if (ms_next >= period_ms)
			begin
				exp_next = 1'b1;
				ms_next = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre_reg <= '0;
			ms_reg <= '0;
			exp_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_next;
			ms_reg <= ms_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;

endmodule : cnes_ms_timer
`default_nettype wire

// file: cnes_slave.sv
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: Send an emergency frame on every internal error or CAN bus error.
// R2: Emergency frames always carry eight data bytes.
// R3: Bytes: code low, code high, error register, then info zero to four.
// R4: When an error condition clears, send emergency code zero.
// R5: Battery loss sends 0x3200, info zero 0xA0, rest zero.
// R6: Bad PDO mapping sends 0x6300 with map index and entry count.
// R7: Heartbeat consumer timeout sends 0x8100 with node ID and timer value.
// R8: SDO block failure sends 0x8100, 0xF1, index and subindex.
// R9: Guarding failure sends 0x8130 with guard time and life factor.
// R10: Short PDO is dropped with 0x8210; long PDO flagged with 0x8220.
// R11: Master sends commands on identifier zero with two data bytes.
// R12: Byte zero is command, byte one node ID; act on own ID or zero.
// R13: Enter initialization automatically after power-up.
// R14: After initialization go pre-operational and send boot-up frame.
// R15: Command 0x01 enters operational, enables outputs and PDO.
// R16: Command 0x02 stops, outputs to error state, SDO and PDO off.
// R17: Command 0x80 enters pre-operational, PDO off, SDO kept.
// R18: Command 0x81 resets the whole node, then re-initializes.
// R19: Command 0x82 restores communication objects, then re-initializes.
// R20: Commands act in every state; unknown or foreign ones ignored.
// R21: Guarding starts at first guard request; reply on 0x700 plus ID.
// R22: No guard request within guard time times life factor: pre-operational.
// R23: Zero guard time or life factor disables guarding expiry.
// R24: Nonzero heartbeat time sends state on 0x700 plus ID at expiry.
module cnes_slave
	import cnes_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DFLT,
	parameter int INIT_CYCLES = INIT_CYCLES_DFLT
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [10:0] tx_id,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	output logic pdo_rx_valid,
	output logic [63:0] pdo_rx_data,
	output logic sdo_rx_valid,
	output logic [63:0] sdo_rx_data,
	output logic outputs_enable,
	output logic outputs_error,
	output logic pdo_tx_enable,
	output logic app_reset,
	input wire logic batt_fail,
	input wire logic err_clear,
	input wire logic can_bus_err,
	input wire logic map_fault,
	input wire logic [15:0] map_index,
	input wire logic [7:0] map_entries,
	input wire logic hbc_timeout,
	input wire logic [6:0] hbc_node,
	input wire logic [15:0] hbc_timer,
	input wire logic sdo_blk_fail,
	input wire logic [15:0] sdo_index,
	input wire logic [7:0] sdo_subindex
);

	function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction : apply_be

	function automatic logic [6:0] state_code(input cnes_state_t s);
		case (s)
			ST_OPER: return CODE_OPER;
			ST_STOP: return CODE_STOP;
			ST_PREOP: return CODE_PREOP;
			default: return CODE_BOOT;
		endcase
	endfunction : state_code

	function automatic logic [15:0] src_code(input int i);
		case (i)
			SRC_BATT: return EC_BATT;
			SRC_MAP: return EC_MAP;
			SRC_HBC: return EC_HBC;
			SRC_SDOB: return EC_SDOB;
			SRC_GUARD: return EC_GUARD;
			SRC_PDO_SHORT: return EC_PDO_SHORT;
			SRC_PDO_LONG: return EC_PDO_LONG;
			SRC_CANERR: return EC_CANERR;
			default: return EC_RESET;
		endcase
	endfunction : src_code

	//////////////////////////////////////////////////////////////////////////////
	cnes_state_t state_reg, state_next;
	logic [31:0] init_cnt_reg, init_cnt_next;
	logic [6:0] node_reg, node_next;
	logic [15:0] guard_time_reg, guard_time_next, hb_time_reg, hb_time_next;
	logic [7:0] life_reg, life_next, err_reg, err_next;
	logic [3:0] rpdo_len_reg, rpdo_len_next;
	logic done_reg, done_next;
	logic [31:0] rdata_reg, rdata_next;
	logic guard_act_reg, guard_act_next, toggle_reg, toggle_next;
	logic guard_pend_reg, guard_pend_next, boot_pend_reg, boot_pend_next, hb_pend_reg, hb_pend_next;
	logic [NSRC-1:0] emcy_pend_reg, emcy_pend_next;
	logic [NSRC-1:0][39:0] info_reg, info_next;
	logic emcy_act_reg, emcy_act_next, batt_q_reg, batt_q_next;
	logic tx_valid_reg, tx_valid_next;
	logic [10:0] tx_id_reg, tx_id_next;
	logic [3:0] tx_dlc_reg, tx_dlc_next;
	logic [63:0] tx_data_reg, tx_data_next, pdo_data_reg, pdo_data_next, sdo_data_reg, sdo_data_next;
	logic pdo_v_reg, pdo_v_next, sdo_v_reg, sdo_v_next, app_rst_reg, app_rst_next;
	logic nmt_hit, guard_rq, rpdo_hit, sdo_hit, life_exp, hb_exp, sent;
	logic [7:0] cs;
	logic [23:0] life_ms;
	logic [31:0] wr_old;

	assign cs = rx_data[7:0];
	assign nmt_hit = rx_valid && !rx_rtr && rx_id == ID_NMT && rx_dlc == NMT_DLC
		&& (rx_data[15:8] == {1'b0, node_reg} || rx_data[15:8] == NODE_BCAST); // R11 R12
	assign guard_rq = rx_valid && rx_rtr && rx_id == ID_GUARD_BASE + 11'(node_reg); // R21
	assign rpdo_hit = rx_valid && !rx_rtr && rx_id == ID_RPDO_BASE + 11'(node_reg);
	assign sdo_hit = rx_valid && !rx_rtr && rx_id == ID_SDO_RX_BASE + 11'(node_reg);
	assign life_ms = 24'(guard_time_reg) * 24'(life_reg);
	assign sent = tx_valid_reg && tx_ready;

	// The guard timer is held while guarding is idle, so expiry counts only from a request.
	cnes_ms_timer #(.MS_CYCLES(MS_CYCLES), .W(24)) u_life (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.restart(guard_rq || !guard_act_reg),
		.period_ms(life_ms),
		.expired(life_exp)
	);

	cnes_ms_timer #(.MS_CYCLES(MS_CYCLES), .W(16)) u_hb (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.restart(state_reg == ST_INIT),
		.period_ms(hb_time_reg),
		.expired(hb_exp)
	);

	//////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_next = state_reg;
		init_cnt_next = init_cnt_reg;
		node_next = node_reg;
		guard_time_next = guard_time_reg;
		life_next = life_reg;
		hb_time_next = hb_time_reg;
		err_next = err_reg;
		rpdo_len_next = rpdo_len_reg;
		done_next = (avs_read || avs_write) && !done_reg;
		rdata_next = rdata_reg;
		guard_act_next = guard_act_reg;
		toggle_next = toggle_reg;
		guard_pend_next = guard_pend_reg;
		boot_pend_next = boot_pend_reg;
		hb_pend_next = hb_pend_reg;
		emcy_pend_next = emcy_pend_reg;
		info_next = info_reg;
		emcy_act_next = emcy_act_reg;
		batt_q_next = batt_fail;
		tx_valid_next = tx_valid_reg && !tx_ready;
		tx_id_next = tx_id_reg;
		tx_dlc_next = tx_dlc_reg;
		tx_data_next = tx_data_reg;
		pdo_v_next = 1'b0;
		pdo_data_next = pdo_data_reg;
		sdo_v_next = sdo_hit && (state_reg == ST_PREOP || state_reg == ST_OPER); // R16 R17
		sdo_data_next = sdo_hit ? rx_data : sdo_data_reg;
		app_rst_next = 1'b0;
		wr_old = '0;

		// Register read data is staged in the wait cycle.
		if (avs_read && !done_reg)
		begin
			case (avs_address)
				ADDR_STATUS: rdata_next = 32'(state_code(state_reg))
					| (32'(guard_act_reg) << STAT_GUARD_BIT) | (32'(emcy_act_reg) << STAT_EMCY_BIT);
				ADDR_NODE_ID: rdata_next = 32'(node_reg);
				ADDR_GUARD_TIME: rdata_next = 32'(guard_time_reg);
				ADDR_LIFE: rdata_next = 32'(life_reg);
				ADDR_HB_TIME: rdata_next = 32'(hb_time_reg);
				ADDR_ERR_REG: rdata_next = 32'(err_reg);
				ADDR_RPDO_LEN: rdata_next = 32'(rpdo_len_reg);
				default: rdata_next = '0;
			endcase
		end
		if (avs_write && done_reg)
		begin
			case (avs_address)
				ADDR_NODE_ID: wr_old = 32'(node_reg);
				ADDR_GUARD_TIME: wr_old = 32'(guard_time_reg);
				ADDR_LIFE: wr_old = 32'(life_reg);
				ADDR_HB_TIME: wr_old = 32'(hb_time_reg);
				ADDR_ERR_REG: wr_old = 32'(err_reg);
				ADDR_RPDO_LEN: wr_old = 32'(rpdo_len_reg);
				default: wr_old = '0;
			endcase
			wr_old = apply_be(wr_old, avs_writedata, avs_byteenable);
			case (avs_address)
				ADDR_NODE_ID: node_next = wr_old[6:0];
				ADDR_GUARD_TIME: guard_time_next = wr_old[15:0];
				ADDR_LIFE: life_next = wr_old[7:0];
				ADDR_HB_TIME: hb_time_next = wr_old[15:0];
				ADDR_ERR_REG: err_next = wr_old[7:0];
				ADDR_RPDO_LEN: rpdo_len_next = wr_old[3:0];
				default: ;
			endcase
		end

		// Transmit slot: frames are offered one at a time, emergencies first.
		if (!tx_valid_next)
		begin
			if (emcy_pend_reg != '0)
			begin
				for (int i = NSRC - 1; i >= 0; i--)
				begin
					if (emcy_pend_reg[i])
					begin
						tx_data_next = {info_reg[i], err_reg, src_code(i)}; // R2 R3
						tx_id_next = ID_EMCY_BASE + 11'(node_reg);
					end
				end
				tx_dlc_next = EMCY_DLC; // R2
				tx_valid_next = 1'b1;
				for (int i = 0; i < NSRC; i++)
				begin
					if (emcy_pend_reg[i] && (emcy_pend_reg & ((NSRC'(1) << i) - NSRC'(1))) == '0)
					begin
						emcy_pend_next[i] = 1'b0;
						emcy_act_next = (i != SRC_CLR);
					end
				end
			end
			else if (guard_pend_reg || boot_pend_reg || hb_pend_reg)
			begin
				tx_id_next = ID_GUARD_BASE + 11'(node_reg); // R21 R24
				tx_dlc_next = STATE_DLC;
				tx_valid_next = 1'b1;
				if (guard_pend_reg)
				begin
					tx_data_next = 64'({toggle_reg, state_code(state_reg)});
					toggle_next = !toggle_reg;
					guard_pend_next = 1'b0;
				end
				else if (boot_pend_reg)
				begin
					tx_data_next = 64'(CODE_BOOT); // R14
					boot_pend_next = 1'b0;
				end
				else
				begin
					tx_data_next = 64'(state_code(state_reg)); // R24
					hb_pend_next = 1'b0;
				end
			end
		end

		// Initialization runs a fixed count, then announces itself.
		if (state_reg == ST_INIT)
		begin
			init_cnt_next = init_cnt_reg + 32'd1;
			if (init_cnt_reg >= 32'(INIT_CYCLES - 1))
			begin
				state_next = ST_PREOP; // R14
				boot_pend_next = 1'b1; // R14
				init_cnt_next = '0;
			end
		end

		// Guarding: a request arms supervision and queues a toggled reply.
		if (guard_rq)
		begin
			guard_act_next = 1'b1; // R21
			guard_pend_next = 1'b1; // R21
		end
		if (life_exp && guard_act_reg && life_ms != '0) // R23
		begin
			guard_act_next = 1'b0;
			if (state_reg != ST_INIT)
				state_next = ST_PREOP; // R22
			emcy_pend_next[SRC_GUARD] = 1'b1; // R9
			info_next[SRC_GUARD] = {16'h0000, life_reg, guard_time_reg[15:8], guard_time_reg[7:0]}; // R9
		end
		if (hb_exp && state_reg != ST_INIT)
			hb_pend_next = 1'b1; // R24

		// Receive PDOs only in operational; a short one is dropped, a long one flagged.
		if (rpdo_hit && state_reg == ST_OPER)
		begin
			pdo_data_next = rx_data;
			pdo_v_next = rx_dlc >= rpdo_len_reg; // R10
			if (rx_dlc != rpdo_len_reg)
			begin
				emcy_pend_next[rx_dlc < rpdo_len_reg ? SRC_PDO_SHORT : SRC_PDO_LONG] = 1'b1; // R10
				info_next[rx_dlc < rpdo_len_reg ? SRC_PDO_SHORT : SRC_PDO_LONG] =
					{16'h0000, 4'h0, rpdo_len_reg, 4'h0, rx_dlc, RPDO_NUMBER}; // R10
			end
		end

		// Events are set after the slot clears its bit, so a new event is never lost.
		if (batt_fail && !batt_q_reg)
		begin
			emcy_pend_next[SRC_BATT] = 1'b1; // R1 R5
			info_next[SRC_BATT] = {32'h00000000, INFO_BATT}; // R5
		end
		if ((!batt_fail && batt_q_reg) || err_clear)
			if (emcy_act_reg || emcy_pend_reg[NSRC-1:1] != '0)
			begin
				emcy_pend_next[SRC_CLR] = 1'b1; // R4
				info_next[SRC_CLR] = '0; // R4
			end
		if (can_bus_err)
		begin
			emcy_pend_next[SRC_CANERR] = 1'b1; // R1
			info_next[SRC_CANERR] = '0;
		end
		if (map_fault)
		begin
			emcy_pend_next[SRC_MAP] = 1'b1; // R6
			info_next[SRC_MAP] = {16'h0000, map_entries, map_index[15:8], map_index[7:0]}; // R6
		end
		if (hbc_timeout)
		begin
			emcy_pend_next[SRC_HBC] = 1'b1; // R7
			info_next[SRC_HBC] = {16'h0000, hbc_timer[15:8], hbc_timer[7:0], 1'b0, hbc_node}; // R7
		end
		if (sdo_blk_fail)
		begin
			emcy_pend_next[SRC_SDOB] = 1'b1; // R8
			info_next[SRC_SDOB] = {8'h00, sdo_subindex, sdo_index[15:8], sdo_index[7:0], INFO_SDOB}; // R8
		end

		// Commands are last so they win over guarding and initialization.
		if (nmt_hit) // R20
		begin
			case (cs)
				CS_START: state_next = ST_OPER; // R15
				CS_STOP: state_next = ST_STOP; // R16
				CS_PREOP: state_next = ST_PREOP; // R17
				CS_RESET_NODE, CS_RESET_COMM:
				begin
					state_next = ST_INIT; // R18 R19
					init_cnt_next = '0;
					guard_time_next = GUARD_TIME_DFLT; // R19
					life_next = LIFE_DFLT;
					hb_time_next = HB_TIME_DFLT;
					err_next = ERR_REG_DFLT;
					rpdo_len_next = RPDO_LEN_DFLT;
					guard_act_next = 1'b0;
					toggle_next = 1'b0;
					guard_pend_next = 1'b0;
					boot_pend_next = 1'b0;
					hb_pend_next = 1'b0;
					app_rst_next = (cs == CS_RESET_NODE); // R18
				end
				default: ; // R20
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= ST_INIT; // R13
			init_cnt_reg <= '0;
			node_reg <= NODE_ID_DFLT;
			guard_time_reg <= GUARD_TIME_DFLT;
			life_reg <= LIFE_DFLT;
			hb_time_reg <= HB_TIME_DFLT;
			err_reg <= ERR_REG_DFLT;
			rpdo_len_reg <= RPDO_LEN_DFLT;
			done_reg <= 1'b0;
			rdata_reg <= '0;
			guard_act_reg <= 1'b0;
			toggle_reg <= 1'b0;
			guard_pend_reg <= 1'b0;
			boot_pend_reg <= 1'b0;
			hb_pend_reg <= 1'b0;
			emcy_pend_reg <= '0;
			info_reg <= '0;
			emcy_act_reg <= 1'b0;
			batt_q_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_id_reg <= '0;
			tx_dlc_reg <= '0;
			tx_data_reg <= '0;
			pdo_v_reg <= 1'b0;
			pdo_data_reg <= '0;
			sdo_v_reg <= 1'b0;
			sdo_data_reg <= '0;
			app_rst_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			init_cnt_reg <= init_cnt_next;
			node_reg <= node_next;
			guard_time_reg <= guard_time_next;
			life_reg <= life_next;
			hb_time_reg <= hb_time_next;
			err_reg <= err_next;
			rpdo_len_reg <= rpdo_len_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			guard_act_reg <= guard_act_next;
			toggle_reg <= toggle_next;
			guard_pend_reg <= guard_pend_next;
			boot_pend_reg <= boot_pend_next;
			hb_pend_reg <= hb_pend_next;
			emcy_pend_reg <= emcy_pend_next;
			info_reg <= info_next;
			emcy_act_reg <= emcy_act_next;
			batt_q_reg <= batt_q_next;
			tx_valid_reg <= tx_valid_next;
			tx_id_reg <= tx_id_next;
			tx_dlc_reg <= tx_dlc_next;
			tx_data_reg <= tx_data_next;
			pdo_v_reg <= pdo_v_next;
			pdo_data_reg <= pdo_data_next;
			sdo_v_reg <= sdo_v_next;
			sdo_data_reg <= sdo_data_next;
			app_rst_reg <= app_rst_next;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !done_reg;
	assign avs_readdata = rdata_reg;
	assign tx_valid = tx_valid_reg;
	assign tx_id = tx_id_reg;
	assign tx_dlc = tx_dlc_reg;
	assign tx_data = tx_data_reg;
	assign pdo_rx_valid = pdo_v_reg;
	assign pdo_rx_data = pdo_data_reg;
	assign sdo_rx_valid = sdo_v_reg;
	assign sdo_rx_data = sdo_data_reg;
	assign outputs_enable = state_reg == ST_OPER; // R15
	assign pdo_tx_enable = state_reg == ST_OPER; // R15 R17
	assign outputs_error = state_reg == ST_STOP; // R16
	assign app_reset = app_rst_reg;

	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_cmd(logic [7:0] c);
		nmt_hit && cs == c;
	endsequence

	a_nmt_start: assert property (s_cmd(CS_START) |=> state_reg == ST_OPER && outputs_enable && pdo_tx_enable) // R15
		else $error("start command did not enter operational");
	a_nmt_stop: assert property (s_cmd(CS_STOP) |=> outputs_error && !outputs_enable ##1 !sdo_rx_valid) // R16
		else $error("stop command did not stop the node");
	a_nmt_preop: assert property (s_cmd(CS_PREOP) |=> state_reg == ST_PREOP && !pdo_tx_enable) // R17
		else $error("pre-operational command not obeyed");
	a_node_reset: assert property (s_cmd(CS_RESET_NODE) |=> app_reset && state_reg == ST_INIT ##1 !app_reset) // R18
		else $error("node reset pulse or state wrong");
	a_comm_reset: assert property (s_cmd(CS_RESET_COMM) |=> guard_time_reg == GUARD_TIME_DFLT
		&& hb_time_reg == HB_TIME_DFLT && !app_reset) // R19
		else $error("communication reset did not restore objects");
	a_foreign_cmd: assert property (rx_valid && rx_id == ID_NMT && rx_dlc == NMT_DLC
		&& rx_data[15:8] != {1'b0, node_reg} && rx_data[15:8] != NODE_BCAST && !life_exp
		&& state_reg != ST_INIT |=> $stable(state_reg)) // R20
		else $error("foreign command changed state");
	a_boot_msg: assert property (state_reg == ST_INIT ##1 state_reg == ST_PREOP |-> boot_pend_reg || tx_valid) // R14
		else $error("boot-up frame not queued");
	a_emcy_len: assert property (tx_valid && tx_id == ID_EMCY_BASE + 11'(node_reg) |-> tx_dlc == EMCY_DLC
		&& tx_data[23:16] == err_reg) // R2 R3
		else $error("emergency frame malformed");
	a_guard_fall: assert property (life_exp && guard_act_reg && life_ms != '0 && !nmt_hit && state_reg != ST_INIT
		|=> state_reg == ST_PREOP && emcy_pend_reg[SRC_GUARD]) // R22
		else $error("guarding expiry not handled");
	a_pdo_short: assert property (rpdo_hit && state_reg == ST_OPER && rx_dlc < rpdo_len_reg |=> !pdo_rx_valid) // R10
		else $error("short PDO was passed on");
	a_hb_queue: assert property (hb_exp && state_reg != ST_INIT |=> hb_pend_reg || tx_valid) // R24
		else $error("heartbeat not queued");

endmodule : cnes_slave
`default_nettype wire

// file: cnes_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module cnes_master_model
	import cnes_pkg::*;
(
	input wire logic clk_sys,
	output logic tx_ready = 1'b0,
	output logic rx_valid = 1'b0,
	output logic [10:0] rx_id = 11'h000,
	output logic rx_rtr = 1'b0,
	output logic [3:0] rx_dlc = 4'h0,
	output logic [63:0] rx_data = 64'h0
);
	logic [2:0] cnt = 3'h0;
	bit busy = 1'b0;
	// Ready stalls half the time so frames see prompt and slow acceptance; idle data toggles so stale bytes never match.
	always @(posedge clk_sys)
	begin
		cnt <= cnt + 3'h1;
		tx_ready <= cnt[2];
		if (!busy)
			rx_data <= ~rx_data;
	end
	task automatic nmt(input logic [7:0] cs, input logic [7:0] node);
		busy = 1'b1;
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_id <= ID_NMT;
		rx_dlc <= NMT_DLC;
		rx_data <= {48'h0, node, cs};
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		busy = 1'b0;
	endtask : nmt
endmodule : cnes_master_model
`default_nettype wire

// file: test_canopen_nmt_emergency_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_canopen_nmt_emergency_slave
	import cnes_pkg::*;
;
	logic clk_sys, arst_n, avs_read, avs_write, avs_waitrequest, tx_valid, tx_ready, rx_valid, rx_rtr, batt_fail;
	logic outputs_enable, outputs_error, pdo_tx_enable;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r, e, g, seed = 32'hF4F2;
	logic [10:0] tx_id, rx_id;
	logic [3:0] tx_dlc, rx_dlc;
	logic [4:0] ev;
	logic [63:0] tx_data, rx_data, xd[5];
	logic [78:0] q[$];
	logic [7:0] cs_t[5] = '{CS_START, CS_STOP, CS_START, 8'h33, CS_PREOP};
	logic [7:0] nd_t[5] = '{8'h01, NODE_BCAST, 8'h05, 8'h00, 8'h01};
	logic [2:0] ot_t[5] = '{3'h5, 3'h2, 3'h2, 3'h2, 3'h0};
	int n_errors = 0, comparisons = 0, cyc = 0;
	cnes_slave #(.MS_CYCLES(20), .INIT_CYCLES(2)) i_dut (.clk_sys, .arst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .rx_valid, .rx_id, .rx_rtr,
		.rx_dlc, .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .pdo_rx_valid(), .pdo_rx_data(),
		.sdo_rx_valid(), .sdo_rx_data(), .outputs_enable, .outputs_error, .pdo_tx_enable, .app_reset(),
		.batt_fail, .err_clear(ev[4]), .can_bus_err(ev[3]), .map_fault(ev[0]), .map_index(e[15:0]),
		.map_entries(e[23:16]), .hbc_timeout(ev[1]), .hbc_node(e[6:0]), .hbc_timer(e[15:0]),
		.sdo_blk_fail(ev[2]), .sdo_index(e[15:0]), .sdo_subindex(e[23:16]));
	cnes_master_model i_mst (.clk_sys, .tx_ready, .rx_valid, .rx_id, .rx_rtr, .rx_dlc, .rx_data);
//////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input logic [78:0] got, input logic [78:0] want);
		comparisons++;
		if (got !== want)
			$display("wrong value at %0t: got %h, want %h", $time, got, want);
		if (got !== want)
			n_errors++;
	endtask : chk
	task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Every accepted frame is matched against the oldest expectation, so lost or extra frames show up too.
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			finish_test();
		end
		else if (tx_valid === 1'b1 && tx_ready === 1'b1)
			chk({tx_id, tx_dlc, tx_data}, (q.size() > 0) ? q.pop_front() : 79'h0);
	end
	initial
	begin
		{arst_n, avs_read, avs_write, batt_fail, ev, e} = '0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		q.push_back({ID_GUARD_BASE + 11'h001, STATE_DLC, 64'h0});
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (20) @(posedge clk_sys);
		av(1'b0, ADDR_STATUS, 32'h0);
		chk(79'(r[6:0]), 79'(CODE_PREOP));
		av(1'b0, 8'hFC, 32'h0);
		chk(79'(r), 79'h0);
		for (int i = 0; i < 5; i++)
		begin
			i_mst.nmt(cs_t[i], nd_t[i]);
			repeat (2) @(posedge clk_sys);
			chk(79'({outputs_enable, outputs_error, pdo_tx_enable}), 79'(ot_t[i]));
		end
		$display("test nmt done");
		g <= xs();
		e <= xs();
		@(posedge clk_sys);
		av(1'b1, ADDR_ERR_REG, 32'(g[7:0]));
		xd = '{{16'h0, e[23:16], e[15:8], e[7:0], g[7:0], EC_MAP}, {16'h0, e[15:8], e[7:0], 1'b0, e[6:0], g[7:0], EC_HBC},
			{8'h0, e[23:16], e[15:8], e[7:0], INFO_SDOB, g[7:0], EC_SDOB}, {40'h0, g[7:0], EC_CANERR},
			{40'h0, g[7:0], EC_RESET}};
		for (int i = 0; i < 5; i++)
		begin
			q.push_back({ID_EMCY_BASE + 11'h001, EMCY_DLC, xd[i]});
			ev[i] <= 1'b1;
			@(posedge clk_sys);
			ev[i] <= 1'b0;
			repeat (20) @(posedge clk_sys);
		end
		q.push_back({ID_EMCY_BASE + 11'h001, EMCY_DLC, 32'h0, INFO_BATT, g[7:0], EC_BATT});
		batt_fail <= 1'b1;
		repeat (20) @(posedge clk_sys);
		q.push_back({ID_EMCY_BASE + 11'h001, EMCY_DLC, 40'h0, g[7:0], EC_RESET});
		batt_fail <= 1'b0;
		repeat (20) @(posedge clk_sys);
		$display("test emergency done");
		q.push_back({ID_GUARD_BASE + 11'h001, STATE_DLC, 64'h0});
		i_mst.nmt(CS_RESET_COMM, NODE_BCAST);
		repeat (20) @(posedge clk_sys);
		av(1'b0, ADDR_ERR_REG, 32'h0);
		chk(79'(r), 79'(ERR_REG_DFLT));
		av(1'b0, ADDR_STATUS, 32'h0);
		chk(79'(r[6:0]), 79'(CODE_PREOP));
		chk(79'(q.size()), 79'h0);
		$display("test reset done");
		finish_test();
	end
endmodule : test_canopen_nmt_emergency_slave
`default_nettype wire
